// ===== verilog/bsl_boot_loader.sv
// Boot stream loader: parses headers, loads blocks, runs init code, hands off
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Function
// - Stream opens with 32-bit little-endian global header
// - Count block header: size four, ignore flag
// - Image byte count follows, little-endian
// - Block header: address, count, flags, little-endian
// - Payload bytes arrive in swapped groups of four
// - Each image starts with its own count block
// - Init blocks run right after loading
// - Active read pointer, rewritable by init code
// - Resume fetching from active pointer after init
// - One image, then jump to entry address
// - Clear destination ranges before loading
// - Only permitted ranges accepted as destinations
// - Second core data bank A upper range allowed
// - Scratch memory is never a destination
// - Reject global header with bad signature
// - Global header bit 0 selects flash width
// - Decode zero-fill and final flags
// - Ignored blocks are skipped, not written
module bsl_boot_loader
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Boot stream source
  output logic             stream_req,
  output logic [31:0]      stream_addr,
  input  wire logic [7:0]  stream_data,
  input  wire logic        stream_valid,
  // Memory write port
  output logic             mem_req,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  output logic [3:0]       mem_be,
  input  wire logic        mem_ready,
  // Init code and hand-off
  output logic             init_exec,
  output logic [31:0]      init_entry,
  output logic             jump_valid,
  output logic [31:0]      jump_addr,
  output logic             flash_wide
);
  bsl_pkg::bsl_state_e st_q;
  bsl_pkg::bsl_state_e hdr_nxt;
  bsl_pkg::bsl_state_e blk_nxt;
  logic [31:0] flash_boot_read_pointer_q;
  logic [31:0] spi_boot_read_pointer_q;
  logic [31:0] base_q, len_q, bidx_q, img_cnt_q, wr_addr_q, init_entry_q, ghdr_q;
  logic [79:0] hdr_q, nxt_hdr;
  logic [31:0] h_addr, h_cnt, h_last, rd_val, hrdata_q;
  logic [15:0] h_flag;
  logic [7:0]  wr_byte_q, ap_ofs_q;
  logic [3:0]  err_q;
  logic        spi_sel_q, go_q, first_hdr_q, cnt_blk_q, init_blk_q, final_blk_q;
  logic        wr_pend_q, init_exec_q, ap_wr_q;
  logic        take_strm, prod, blk_done, hdr_end, ign, dest_ok, dest_scr;
  logic        clr_start, wr_ctrl, init_ret, start_wr;

  bsl_clr_if clr ();

  bsl_clear_engine u_clear
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (clr.eng)
  );

  bsl_dest_check u_dest
  (
    .first   (h_addr),
    .last    (h_last),
    .ok      (dest_ok),
    .scratch (dest_scr)
  );

  function automatic logic wr_hit(input logic [7:0] ofs);
    return ap_wr_q && ap_ofs_q == ofs;
  endfunction

  // Bus answers with zero wait states
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign wr_ctrl   = wr_hit(bsl_pkg::OFS_CTRL);
  assign start_wr  = wr_ctrl && hwdata[bsl_pkg::CTRL_START];
  assign init_ret  = wr_ctrl && hwdata[bsl_pkg::CTRL_INIT_RET] && st_q == bsl_pkg::ST_INIT;

  // Header decode
  always_comb
  begin
    nxt_hdr = hdr_q;
    nxt_hdr[{bidx_q[3:0], 3'b000} +: 8] = stream_data;
  end
  assign h_addr  = nxt_hdr[31:0];
  assign h_cnt   = nxt_hdr[63:32];
  assign h_flag  = nxt_hdr[79:64];
  assign h_last  = h_addr + h_cnt - 32'h0000_0001;
  assign ign     = first_hdr_q || h_flag[bsl_pkg::FLG_IGNORE];
  assign hdr_end = st_q == bsl_pkg::ST_HDR && take_strm
    && bidx_q == 32'(bsl_pkg::HDR_BYTES - 1);

  always_comb
  begin
    if (ign)
      hdr_nxt = (h_cnt == 32'h0000_0000) ? bsl_pkg::ST_HDR : bsl_pkg::ST_SKIP;
    else if (h_cnt != 32'h0000_0000 && (dest_scr || !dest_ok))
      hdr_nxt = bsl_pkg::ST_ERR;
    else if (h_flag[bsl_pkg::FLG_ZERO])
      hdr_nxt = bsl_pkg::ST_ZFILL;
    else
      hdr_nxt = bsl_pkg::ST_LOAD;
  end

  always_comb
  begin
    if (init_blk_q)
      blk_nxt = bsl_pkg::ST_INIT;
    else if (final_blk_q)
      blk_nxt = bsl_pkg::ST_DONE;
    else
      blk_nxt = bsl_pkg::ST_HDR;
  end

  // Byte source and sink
  assign stream_req = (st_q == bsl_pkg::ST_GHDR || st_q == bsl_pkg::ST_HDR
    || st_q == bsl_pkg::ST_SKIP
    || (st_q == bsl_pkg::ST_LOAD && !wr_pend_q && bidx_q != len_q));
  assign stream_addr = spi_sel_q ? spi_boot_read_pointer_q : flash_boot_read_pointer_q;
  assign take_strm   = stream_req && stream_valid;
  assign prod = (st_q == bsl_pkg::ST_LOAD && take_strm)
    || (st_q == bsl_pkg::ST_ZFILL && !wr_pend_q && bidx_q != len_q);
  assign blk_done = (st_q == bsl_pkg::ST_LOAD || st_q == bsl_pkg::ST_ZFILL)
    && !wr_pend_q && bidx_q == len_q;
  assign clr_start = go_q && (st_q == bsl_pkg::ST_IDLE || st_q == bsl_pkg::ST_DONE
    || st_q == bsl_pkg::ST_ERR);

  assign clr.start = clr_start;
  assign clr.ready = mem_ready;
  assign mem_req   = clr.req || wr_pend_q;
  assign mem_addr  = clr.req ? clr.addr : {wr_addr_q[31:2], 2'b00};
  assign mem_wdata = clr.req ? 32'h0000_0000 : {4{wr_byte_q}};
  assign mem_be    = clr.req ? 4'hF : 4'b0001 << wr_addr_q[1:0];

  assign init_exec  = init_exec_q;
  assign init_entry = init_entry_q;
  assign jump_valid = st_q == bsl_pkg::ST_DONE;
  assign jump_addr  = bsl_pkg::ENTRY_ADDR;
  assign flash_wide = ghdr_q[bsl_pkg::WIDE_BIT];

  // Stream parser
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q         <= bsl_pkg::ST_IDLE;
      bidx_q       <= 32'h0000_0000;
      base_q       <= 32'h0000_0000;
      len_q        <= 32'h0000_0000;
      ghdr_q       <= 32'h0000_0000;
      hdr_q        <= 80'h0;
      img_cnt_q    <= 32'h0000_0000;
      init_entry_q <= 32'h0000_0000;
      err_q        <= bsl_pkg::ERR_NONE;
      first_hdr_q  <= 1'b0;
      cnt_blk_q    <= 1'b0;
      init_blk_q   <= 1'b0;
      final_blk_q  <= 1'b0;
      init_exec_q  <= 1'b0;
    end
    else
    begin
      init_exec_q <= 1'b0;
      unique case (st_q)
        bsl_pkg::ST_IDLE, bsl_pkg::ST_DONE, bsl_pkg::ST_ERR:
          if (clr_start)
          begin
            st_q  <= bsl_pkg::ST_CLEAR;
            err_q <= bsl_pkg::ERR_NONE;
          end
        bsl_pkg::ST_CLEAR:
          if (clr.done)
          begin
            st_q   <= bsl_pkg::ST_GHDR;
            bidx_q <= 32'h0000_0000;
          end
        bsl_pkg::ST_GHDR:
          if (take_strm)
          begin
            ghdr_q[{bidx_q[1:0], 3'b000} +: 8] <= stream_data;
            bidx_q <= bidx_q + 32'h0000_0001;
            if (bidx_q == 32'(bsl_pkg::GHDR_BYTES - 1))
            begin
              bidx_q <= 32'h0000_0000;
              if (stream_data[bsl_pkg::SIG_LSB - 24 +: 4] != bsl_pkg::SIG_VALID)
              begin
                st_q  <= bsl_pkg::ST_ERR;
                err_q <= bsl_pkg::ERR_SIG;
              end
              else
              begin
                st_q        <= bsl_pkg::ST_HDR;
                first_hdr_q <= 1'b1;
              end
            end
          end
        bsl_pkg::ST_HDR:
          if (take_strm)
          begin
            hdr_q  <= nxt_hdr;
            bidx_q <= bidx_q + 32'h0000_0001;
            if (hdr_end)
            begin
              bidx_q      <= 32'h0000_0000;
              base_q      <= h_addr;
              len_q       <= h_cnt;
              init_blk_q  <= h_flag[bsl_pkg::FLG_INIT] && !ign;
              final_blk_q <= h_flag[bsl_pkg::FLG_FINAL] && !ign;
              cnt_blk_q   <= first_hdr_q;
              first_hdr_q <= 1'b0;
              st_q        <= hdr_nxt;
              if (hdr_nxt == bsl_pkg::ST_ERR)
                err_q <= dest_scr ? bsl_pkg::ERR_SCRATCH : bsl_pkg::ERR_DEST;
            end
          end
        bsl_pkg::ST_SKIP:
          if (take_strm)
          begin
            bidx_q <= bidx_q + 32'h0000_0001;
            if (cnt_blk_q && bidx_q < 32'(bsl_pkg::CNT_BYTES))
              img_cnt_q[{bidx_q[1:0], 3'b000} +: 8] <= stream_data;
            if (bidx_q == len_q - 32'h0000_0001)
            begin
              st_q   <= bsl_pkg::ST_HDR;
              bidx_q <= 32'h0000_0000;
            end
          end
        bsl_pkg::ST_LOAD, bsl_pkg::ST_ZFILL:
          if (prod)
            bidx_q <= bidx_q + 32'h0000_0001;
          else if (blk_done)
          begin
            bidx_q       <= 32'h0000_0000;
            st_q         <= blk_nxt;
            init_exec_q  <= init_blk_q;
            init_entry_q <= base_q;
          end
        bsl_pkg::ST_INIT:
          if (init_ret)
            st_q <= bsl_pkg::ST_HDR;
        default:
          st_q <= bsl_pkg::ST_IDLE;
      endcase
    end
  end

  // Byte writes into destination memory
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
      wr_byte_q <= 8'h00;
    end
    else if (prod)
    begin
      wr_pend_q <= 1'b1;
      if (st_q == bsl_pkg::ST_LOAD)
      begin
        wr_addr_q <= base_q + (bidx_q ^ 32'h0000_0003);
        wr_byte_q <= stream_data;
      end
      else
      begin
        wr_addr_q <= base_q + bidx_q;
        wr_byte_q <= 8'h00;
      end
    end
    else if (wr_pend_q && mem_ready)
      wr_pend_q <= 1'b0;
  end

  // External read pointers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flash_boot_read_pointer_q <= bsl_pkg::PTR_RST;
      spi_boot_read_pointer_q   <= bsl_pkg::PTR_RST;
    end
    else
    begin
      if (wr_hit(bsl_pkg::OFS_FLASH))
        flash_boot_read_pointer_q <= hwdata;
      else if (clr_start)
        flash_boot_read_pointer_q <= bsl_pkg::PTR_RST;
      else if (take_strm && !spi_sel_q)
        flash_boot_read_pointer_q <= flash_boot_read_pointer_q + 32'h0000_0001;
      if (wr_hit(bsl_pkg::OFS_SPI))
        spi_boot_read_pointer_q <= hwdata;
      else if (clr_start)
        spi_boot_read_pointer_q <= bsl_pkg::PTR_RST;
      else if (take_strm && spi_sel_q)
        spi_boot_read_pointer_q <= spi_boot_read_pointer_q + 32'h0000_0001;
    end
  end

  // Register read values
  always_comb
  begin
    case (haddr[7:0])
      bsl_pkg::OFS_CTRL:   rd_val = {29'h0000_0000, spi_sel_q, 2'b00};
      bsl_pkg::OFS_STATUS: rd_val = {20'h0_0000, err_q, 4'h0, st_q};
      bsl_pkg::OFS_FLASH:  rd_val = flash_boot_read_pointer_q;
      bsl_pkg::OFS_SPI:    rd_val = spi_boot_read_pointer_q;
      bsl_pkg::OFS_GHDR:   rd_val = ghdr_q;
      bsl_pkg::OFS_IMGCNT: rd_val = img_cnt_q;
      default:             rd_val = 32'h0000_0000;
    endcase
  end

  // Bus slave and control bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_wr_q   <= 1'b0;
      ap_ofs_q  <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
      go_q      <= bsl_pkg::GO_RST;
      spi_sel_q <= 1'b0;
    end
    else
    begin
      ap_wr_q  <= hsel && htrans[1] && hready && hwrite;
      ap_ofs_q <= haddr[7:0];
      hrdata_q <= (hsel && htrans[1] && hready && !hwrite) ? rd_val : 32'h0000_0000;
      if (start_wr)
        go_q <= 1'b1;
      else if (clr_start)
        go_q <= 1'b0;
      if (wr_ctrl)
        spi_sel_q <= hwdata[bsl_pkg::CTRL_SPI];
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_sig_reject;
    st_q == bsl_pkg::ST_GHDR && take_strm && bidx_q == 32'h0000_0003
      && stream_data[7:4] != bsl_pkg::SIG_VALID
      |=> st_q == bsl_pkg::ST_ERR && err_q == bsl_pkg::ERR_SIG;
  endproperty
  a_sig_reject: assert property (p_sig_reject)
    else $error("blank stream not rejected");

  property p_wide;
    st_q == bsl_pkg::ST_GHDR && take_strm && bidx_q == 32'h0000_0000
      |=> flash_wide == $past(stream_data[0]);
  endproperty
  a_wide: assert property (p_wide)
    else $error("flash width not taken from header bit 0");

  property p_fields;
    hdr_end && hdr_nxt == bsl_pkg::ST_LOAD
      |=> st_q == bsl_pkg::ST_LOAD && !wr_pend_q && base_q == $past(h_addr)
        && len_q == $past(h_cnt);
  endproperty
  a_fields: assert property (p_fields)
    else $error("block header fields misplaced");

  property p_swap;
    st_q == bsl_pkg::ST_LOAD && take_strm |=> wr_pend_q
      && wr_addr_q == $past(base_q) + ($past(bidx_q) ^ 32'h0000_0003)
      && wr_byte_q == $past(stream_data);
  endproperty
  a_swap: assert property (p_swap)
    else $error("payload byte order wrong");

  property p_skip;
    st_q == bsl_pkg::ST_SKIP |-> !mem_req;
  endproperty
  a_skip: assert property (p_skip)
    else $error("ignored block written to memory");

  property p_count;
    cnt_blk_q && st_q == bsl_pkg::ST_SKIP && take_strm && bidx_q == 32'h0000_0003
      |=> img_cnt_q[31:24] == $past(stream_data) ##1 st_q != bsl_pkg::ST_SKIP;
  endproperty
  a_count: assert property (p_count)
    else $error("image byte count not captured");

  property p_dest;
    hdr_end && !ign && h_cnt != 32'h0000_0000 && (!dest_ok || dest_scr)
      |=> st_q == bsl_pkg::ST_ERR && !mem_req;
  endproperty
  a_dest: assert property (p_dest)
    else $error("forbidden destination accepted");

  property p_init;
    blk_done && init_blk_q |=> init_exec && init_entry == $past(base_q)
      ##1 !init_exec && st_q == bsl_pkg::ST_INIT;
  endproperty
  a_init: assert property (p_init)
    else $error("init block not executed");

  property p_init_wait;
    st_q == bsl_pkg::ST_INIT && !init_ret |=> st_q == bsl_pkg::ST_INIT && !stream_req;
  endproperty
  a_init_wait: assert property (p_init_wait)
    else $error("parsing went on during init code");

  property p_resume;
    st_q == bsl_pkg::ST_INIT && wr_hit(bsl_pkg::OFS_FLASH) && !spi_sel_q
      |=> stream_addr == $past(hwdata);
  endproperty
  a_resume: assert property (p_resume)
    else $error("fetch not resumed at rewritten pointer");

  property p_final;
    blk_done && final_blk_q && !init_blk_q
      |=> jump_valid && jump_addr == bsl_pkg::ENTRY_ADDR;
  endproperty
  a_final: assert property (p_final)
    else $error("no hand-off after final block");

  property p_clear;
    st_q == bsl_pkg::ST_GHDR && $past(st_q) != bsl_pkg::ST_GHDR |-> $past(clr.done);
  endproperty
  a_clear: assert property (p_clear)
    else $error("stream read before memories cleared");

  c_init: cover property (st_q == bsl_pkg::ST_INIT ##[1:1000] st_q == bsl_pkg::ST_HDR);
  c_done: cover property (st_q == bsl_pkg::ST_DONE);
  c_zfill: cover property (st_q == bsl_pkg::ST_ZFILL && wr_pend_q);
  c_err: cover property (st_q == bsl_pkg::ST_ERR && err_q == bsl_pkg::ERR_DEST);
endmodule

// ===== verilog/bsl_pkg.sv
// Constants, memory map, flag positions and state codes of the boot stream loader
package bsl_pkg;

  // Register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FLASH  = 8'h08;
  localparam logic [7:0] OFS_SPI    = 8'h0C;
  localparam logic [7:0] OFS_GHDR   = 8'h10;
  localparam logic [7:0] OFS_IMGCNT = 8'h14;

  // Control bits
  localparam int CTRL_START    = 0;
  localparam int CTRL_INIT_RET = 1;
  localparam int CTRL_SPI      = 2;

  // Reset values
  localparam logic [31:0] PTR_RST = 32'h0000_0000;
  localparam logic        GO_RST  = 1'b1;

  // Stream layout
  localparam int GHDR_BYTES = 4;
  localparam int HDR_BYTES  = 10;
  localparam int CNT_BYTES  = 4;
  localparam int WIDE_BIT   = 0;
  localparam int SIG_LSB    = 28;
  localparam logic [3:0] SIG_VALID = 4'hA;

  // Flag word bit positions
  localparam int FLG_ZERO   = 0;
  localparam int FLG_INIT   = 3;
  localparam int FLG_IGNORE = 4;
  localparam int FLG_FINAL  = 15;

  // Hand-off entry point
  localparam logic [31:0] ENTRY_ADDR = 32'hFFA0_0000;

  // Error codes
  localparam logic [3:0] ERR_NONE    = 4'h0;
  localparam logic [3:0] ERR_SIG     = 4'h1;
  localparam logic [3:0] ERR_DEST    = 4'h2;
  localparam logic [3:0] ERR_SCRATCH = 4'h3;

  // Permitted destinations; the first N_CLEAR are cleared before a boot
  localparam int N_RANGE = 14;
  localparam int N_CLEAR = 13;
  localparam logic [31:0] RANGE_LO [N_RANGE] = '{
    32'hFFA0_0000, 32'hFFA1_0000, 32'hFF80_0000, 32'hFF80_4000,
    32'hFF90_0000, 32'hFF90_4000, 32'hFF60_0000, 32'hFF61_0000,
    32'hFF40_0000, 32'hFF40_4000, 32'hFF50_0000, 32'hFF50_4000,
    32'hFEB0_0000, 32'h0000_0000};
  localparam logic [31:0] RANGE_HI [N_RANGE] = '{
    32'hFFA0_3FFF, 32'hFFA1_3FFF, 32'hFF80_3FFF, 32'hFF80_7FFF,
    32'hFF90_3FFF, 32'hFF90_7FFF, 32'hFF60_3FFF, 32'hFF61_3FFF,
    32'hFF40_3FFF, 32'hFF40_7FFF, 32'hFF50_3FFF, 32'hFF50_7FFF,
    32'hFEB1_FFFF, 32'h1FFF_FFFF};

  // Scratch areas, never a destination
  localparam logic [31:0] SCR_A_LO = 32'hFFB0_0000;
  localparam logic [31:0] SCR_A_HI = 32'hFFB0_0FFF;
  localparam logic [31:0] SCR_B_LO = 32'hFF70_0000;
  localparam logic [31:0] SCR_B_HI = 32'hFF70_0FFF;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_CLEAR = 4'b0001,
    ST_GHDR  = 4'b0011,
    ST_HDR   = 4'b0010,
    ST_SKIP  = 4'b0110,
    ST_LOAD  = 4'b0111,
    ST_ZFILL = 4'b0101,
    ST_INIT  = 4'b0100,
    ST_DONE  = 4'b1100,
    ST_ERR   = 4'b1000
  } bsl_state_e;

  function automatic logic is_scratch(input logic [31:0] a);
    return (a >= SCR_A_LO && a <= SCR_A_HI) || (a >= SCR_B_LO && a <= SCR_B_HI);
  endfunction

endpackage

// ===== verilog/bsl_clr_if.sv
// Link between the loader and its memory clear engine
`timescale 1ns/1ps
interface bsl_clr_if;
  logic        start;
  logic        done;
  logic        req;
  logic        ready;
  logic [31:0] addr;
  modport eng (input start, ready, output done, req, addr);
  modport ctl (output start, ready, input done, req, addr);
endinterface

// ===== verilog/bsl_clear_engine.sv
// Walks every on-chip destination range writing zero words
`timescale 1ns/1ps
module bsl_clear_engine
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Loader side
  bsl_clr_if.eng    clr
);
  logic [3:0]  idx_q;
  logic [31:0] addr_q;
  logic        run_q;
  logic        done_q;

  assign clr.req  = run_q;
  assign clr.addr = addr_q;
  assign clr.done = done_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_q  <= 1'b0;
      done_q <= 1'b0;
      idx_q  <= 4'h0;
      addr_q <= 32'h0000_0000;
    end
    else
    begin
      done_q <= 1'b0;
      if (clr.start && !run_q)
      begin
        run_q  <= 1'b1;
        idx_q  <= 4'h0;
        addr_q <= bsl_pkg::RANGE_LO[0];
      end
      else if (run_q && clr.ready)
      begin
        if (addr_q[31:2] == bsl_pkg::RANGE_HI[idx_q][31:2])
        begin
          if (idx_q == 4'(bsl_pkg::N_CLEAR - 1))
          begin
            run_q  <= 1'b0;
            done_q <= 1'b1;
          end
          else
          begin
            idx_q  <= idx_q + 4'h1;
            addr_q <= bsl_pkg::RANGE_LO[idx_q + 4'h1];
          end
        end
        else
          addr_q <= addr_q + 32'h0000_0004;
      end
    end
  end

  property p_clr_walk;
    @(posedge hclk) disable iff (!hresetn)
    run_q |-> addr_q[1:0] == 2'b00 && addr_q >= bsl_pkg::RANGE_LO[idx_q]
      && addr_q <= bsl_pkg::RANGE_HI[idx_q];
  endproperty
  a_clr_walk: assert property (p_clr_walk)
    else $error("clear address outside its range");
endmodule

// ===== verilog/bsl_dest_check.sv
// Decides whether a block's span lies inside one permitted destination
`timescale 1ns/1ps
module bsl_dest_check
(
  // Span of the block
  input  wire logic [31:0] first,
  input  wire logic [31:0] last,
  // Verdict
  output logic             ok,
  output logic             scratch
);
  logic [bsl_pkg::N_RANGE-1:0] hit;

  for (genvar i = 0; i < bsl_pkg::N_RANGE; i++)
  begin : g_rng
    assign hit[i] = first >= bsl_pkg::RANGE_LO[i] && last <= bsl_pkg::RANGE_HI[i]
      && first <= last;
  end

  assign ok      = |hit;
  assign scratch = bsl_pkg::is_scratch(first) || bsl_pkg::is_scratch(last);
endmodule

// ===== bench/bsl_flash_model.sv
// Boot flash model holding the test stream
`timescale 1ns/1ps
module bsl_flash_model
(
  // Clock and pacing
  input  wire logic        hclk,
  input  wire logic        slow,
  // Stream port
  input  wire logic        stream_req,
  input  wire logic [31:0] stream_addr,
  output logic [7:0]       stream_data,
  output logic             stream_valid
);
  logic [7:0] rom [128];
  logic [7:0] last_q;
  logic       tick_q;
  task automatic put(input int a, input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++)
      rom[a+i] = v[8*i+:8];
  endtask
  // Every block of this stream carries four bytes
  task automatic hdr(input int a, input logic [31:0] ad, input logic [15:0] f);
    put(a, ad, 4);
    put(a + 4, 32'h0000_0004, 4);
    put(a + 8, {16'h0000, f}, 2);
  endtask
  initial
  begin
    stream_valid = 1'b0;
    tick_q = 1'b0;
    last_q = 8'h00;
    for (int i = 0; i < 128; i++)
      rom[i] = 8'hEE;
    put(0, 32'hA000_0001, 4);
    hdr(4, 32'h5555_5555, 16'h0010);
    put(14, 32'h0000_0100, 4);
    hdr(18, 32'hFF40_4000, 16'h0000);
    put(28, 32'h4433_2211, 4);
    hdr(32, 32'hFFA0_0000, 16'h0008);
    put(42, 32'hDDCC_BBAA, 4);
    hdr(64, 32'h5555_5555, 16'h0010);
    put(74, 32'h0000_0100, 4);
    hdr(78, 32'hFEB0_0000, 16'h0001);
    hdr(88, 32'h0000_1000, 16'h8000);
    put(98, 32'h0403_0201, 4);
  end
  // Released line shows the inverted last byte
  assign stream_data = stream_req ? rom[stream_addr[6:0]] : ~last_q;
  always @(posedge hclk)
  begin
    tick_q <= ~tick_q;
    stream_valid <= stream_req && (!slow || tick_q);
    if (stream_req)
      last_q <= rom[stream_addr[6:0]];
  end
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the boot stream loader
`timescale 1ns/1ps
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        stream_req, stream_valid, mem_req, mem_ready, stall;
  logic        init_exec, jump_valid, flash_wide;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  mem_be;
  logic [7:0]  stream_data;
  logic [31:0] haddr, hwdata, hrdata, stream_addr, mem_addr, mem_wdata;
  logic [31:0] init_entry, jump_addr;
  logic [7:0]  wmem [logic [31:0]];
  int          failures = 0;
  int          samples_checked = 0;
  int          clear_cnt = 0;
  assign hready = hreadyout;
  assign stall = clear_cnt >= 81920;
  always #25 hclk = ~hclk;
  bsl_boot_loader i_bsl_boot_loader (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .stream_req,
    .stream_addr, .stream_data, .stream_valid, .mem_req, .mem_addr, .mem_wdata,
    .mem_be, .mem_ready, .init_exec, .init_entry, .jump_valid, .jump_addr, .flash_wide);
  bsl_flash_model i_bsl_flash_model (.hclk, .slow(stall), .stream_req, .stream_addr,
    .stream_data, .stream_valid);
  // Clear words are counted, load bytes kept; memory stalls after clearing
  always @(posedge hclk)
  begin
    mem_ready <= !(stall && mem_ready);
    if (mem_req && mem_ready && mem_be == 4'hF)
      clear_cnt <= clear_cnt + 1;
    else if (mem_req && mem_ready)
      for (int i = 0; i < 4; i++)
        if (mem_be[i])
          wmem[{mem_addr[31:2], i[1:0]}] = mem_wdata[8*i+:8];
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0000_00, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb(1'b1, a, d, rd);
  endtask
  // Byte at base+i must be stream byte i xor 3
  task automatic blk(input logic [31:0] b, input logic [31:0] s);
    for (int i = 0; i < 4; i++)
      chk(wmem.exists(b + i) ? {24'h0, wmem[b+i]} : 32'hFFFF_FFFF, {24'h0, s[8*(i^3)+:8]});
  endtask
  task automatic t_init;
    for (int n = 0; n < 100000 && init_exec !== 1'b1; n++)
      @(posedge hclk);
    chk({31'h0, init_exec}, 32'h1);
    chk(init_entry, 32'hFFA0_0000);
    chk(clear_cnt, 81920);
    blk(32'hFF40_4000, 32'h4433_2211);
    blk(32'hFFA0_0000, 32'hDDCC_BBAA);
    chk({31'h0, wmem.exists(32'h5555_5555)}, 32'h0);
    rchk(bsl_pkg::OFS_STATUS, 32'h0000_0004);
    chk({31'h0, stream_req}, 32'h0);
  endtask
  task automatic t_regs;
    rchk(bsl_pkg::OFS_GHDR, 32'hA000_0001);
    chk({31'h0, flash_wide}, 32'h1);
    rchk(bsl_pkg::OFS_IMGCNT, 32'h0000_0100);
    rchk(bsl_pkg::OFS_SPI, bsl_pkg::PTR_RST);
    rchk(8'h20, 32'h0000_0000);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic t_redirect;
    wr(bsl_pkg::OFS_FLASH, 32'h0000_0040);
    rchk(bsl_pkg::OFS_FLASH, 32'h0000_0040);
    wr(bsl_pkg::OFS_SPI, 32'h0000_0040);
    wr(bsl_pkg::OFS_CTRL, 32'h0000_0006);
    rchk(bsl_pkg::OFS_CTRL, 32'h0000_0004);
    for (int n = 0; n < 2000 && jump_valid !== 1'b1; n++)
      @(posedge hclk);
    chk({31'h0, jump_valid}, 32'h1);
    chk(jump_addr, 32'hFFA0_0000);
    chk({31'h0, stream_req}, 32'h0);
    blk(32'hFEB0_0000, 32'h0000_0000);
    blk(32'h0000_1000, 32'h0403_0201);
    rchk(bsl_pkg::OFS_STATUS, 32'h0000_000C);
    rchk(bsl_pkg::OFS_SPI, 32'h0000_0066);
    rchk(bsl_pkg::OFS_FLASH, 32'h0000_0040);
  endtask
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (95000) @(posedge hclk);
    failures++;
    print_verdict;
  end
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    mem_ready = 1'b1;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_init;
    t_regs;
    t_redirect;
    print_verdict;
  end
endmodule
